/* File: lbbc_pkg.sv */
// lbbc_pkg: operation codes, flag positions, reset values and widths
// for the logic / bit-test / branch / compare execution unit.
// assumes a decoder upstream supplies one operation code per instruction.
package lbbc_pkg;

  localparam int LBBC_DATA_W = 8;
  localparam int LBBC_ADDR_W = 16;

  // operation codes presented on op_code with op_valid
  typedef enum logic [3:0] {
    LBBC_OP_NONE = 4'h0,
    LBBC_OP_AND = 4'h1,
    LBBC_OP_PERIPH_AND = 4'h2,
    LBBC_OP_EXT_BRANCH = 4'h3,
    LBBC_OP_REG_JUMP_ONE = 4'h4,
    LBBC_OP_PERIPH_JUMP_ONE = 4'h5,
    LBBC_OP_REG_JUMP_ZERO = 4'h6,
    LBBC_OP_PERIPH_JUMP_ZERO = 4'h7,
    LBBC_OP_CALL = 4'h8,
    LBBC_OP_CLEAR = 4'h9,
    LBBC_OP_CLEAR_CARRY = 4'hA,
    LBBC_OP_COMPARE = 4'hB,
    LBBC_OP_EXT_A_COMPARE = 4'hC
  } lbbc_op_type;

  // source operand selector
  typedef enum logic [1:0] {
    LBBC_SRC_A = 2'h0,
    LBBC_SRC_B = 2'h1,
    LBBC_SRC_IMM = 2'h2,
    LBBC_SRC_REG = 2'h3
  } lbbc_src_type;

  // extended target addressing modes
  typedef enum logic [1:0] {
    LBBC_XM_DIRECT = 2'h0,
    LBBC_XM_INDIRECT = 2'h1,
    LBBC_XM_INDEXED = 2'h2
  } lbbc_xmode_type;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    LBBC_ST_IDLE = 5'h01,
    LBBC_ST_PREAD = 5'h02,
    LBBC_ST_EXEC = 5'h04,
    LBBC_ST_PUSH_HI = 5'h08,
    LBBC_ST_PUSH_LO = 5'h10
  } lbbc_state_type;

  // flag positions inside the 3-bit status field
  localparam int LBBC_FLAG_C = 0;
  localparam int LBBC_FLAG_N = 1;
  localparam int LBBC_FLAG_Z = 2;
  localparam int LBBC_SIGN_BIT = 7;

  // values after reset
  localparam logic [15:0] LBBC_PC_RST = 16'h0000;
  localparam logic [7:0] LBBC_SP_RST = 8'h00;
  localparam logic [7:0] LBBC_BYTE_RST = 8'h00;
  localparam logic [2:0] LBBC_FLAGS_RST = 3'h0;

endpackage : lbbc_pkg

/* File: lbbc_flags.sv */
// lbbc_flags: sign and zero of an 8-bit value, registered.
// assumes the caller decides when the result is captured.
`timescale 1ns/1ns
module lbbc_flags #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // value and capture
  input wire logic load,
  input wire logic [DATA_W-1:0] value,
  // registered flags
  output logic sign_r,
  output logic zero_r
);
  import lbbc_pkg::*;

  // sign is the top bit, zero only when every bit is clear
  wire sign_nxt = value[DATA_W-1]; // RL17
  wire zero_nxt = (value == '0); // RL17

  // hold between captures
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sign_r <= LBBC_FLAGS_RST[LBBC_FLAG_N];
      zero_r <= LBBC_FLAGS_RST[LBBC_FLAG_Z];
    end else if (clk_en && load) begin
      sign_r <= sign_nxt;
      zero_r <= zero_nxt;
    end
  end

endmodule : lbbc_flags

/* File: lbbc_pf_port.sv */
// lbbc_pf_port: one-shot access port for the peripheral file.
// assumes read data return exactly one cycle after a read strobe.
`timescale 1ns/1ns
module lbbc_pf_port #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // requests from the sequencer
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [DATA_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  // peripheral file pins, all registered
  output logic pf_rd_r,
  output logic pf_wr_r,
  output logic [DATA_W-1:0] pf_addr_r,
  output logic [DATA_W-1:0] pf_wdata_r
);
  import lbbc_pkg::*;

  // strobes last one cycle; address holds for the following data phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pf_rd_r <= 1'b0;
      pf_wr_r <= 1'b0;
      pf_addr_r <= LBBC_BYTE_RST;
      pf_wdata_r <= LBBC_BYTE_RST;
    end else if (clk_en) begin
      pf_rd_r <= rd_req;
      pf_wr_r <= wr_req;
      if (rd_req || wr_req) begin
        pf_addr_r <= addr;
      end
      if (wr_req) begin
        pf_wdata_r <= wdata;
      end
    end
  end

endmodule : lbbc_pf_port

/* File: lbbc_exec.sv */
// lbbc_exec: executes the logic, bit-test jump, extended branch, call,
// clear, clear-carry and compare group on an 8-bit core.
// assumes a decoder hands over operands already fetched from the register
// file, and that peripheral file reads answer one cycle after the strobe.
`timescale 1ns/1ns
// How it works
// RL1: AND two bytes bitwise, write to destination
// RL2: register AND clears carry, flags from result
// RL3: peripheral AND reads, ANDs, writes back, flags
// RL4: peripheral AND source only A, B, immediate
// RL5: extended branch loads pc, flags unchanged
// RL6: branch target direct, indirect or B-indexed
// RL7: jump-if-one on source AND register nonzero
// RL8: peripheral jump-if-one reads peripheral operand
// RL9: jump-if-zero on source AND NOT register
// RL10: offset added to next opcode address
// RL11: peripheral jump-if-zero, same flag effects
// RL12: call pushes pc high then low, loads target
// RL13: clear writes zero, C=0 N=0 Z=1
// RL14: clear carry clears C, N/Z from A
// RL15: compare dest minus source, C on unsigned >=
// RL16: extended compare A minus addressed byte
// RL17: sign is bit 7, zero when all zero
module lbbc_exec #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // instruction handed over by the decoder
  input wire logic op_valid,
  input wire lbbc_pkg::lbbc_op_type op_code,
  input wire lbbc_pkg::lbbc_src_type src_sel,
  input wire lbbc_pkg::lbbc_xmode_type xmode,
  input wire logic [DATA_W-1:0] reg_a,
  input wire logic [DATA_W-1:0] reg_b,
  input wire logic [DATA_W-1:0] src_reg,
  input wire logic [DATA_W-1:0] imm,
  input wire logic [DATA_W-1:0] dst_val,
  input wire logic [DATA_W-1:0] dst_addr,
  input wire logic [DATA_W-1:0] offset,
  input wire logic [ADDR_W-1:0] xaddr,
  input wire logic [ADDR_W-1:0] pair_val,
  input wire logic [DATA_W-1:0] xbyte,
  input wire logic [ADDR_W-1:0] next_pc,
  // peripheral file read data (same clock)
  input wire logic [DATA_W-1:0] pf_rdata,
  // handshake back to the decoder
  output logic busy_r,
  output logic done_r,
  output logic illegal_r,
  // register file write
  output logic rf_we_r,
  output logic [DATA_W-1:0] rf_waddr_r,
  output logic [DATA_W-1:0] rf_wdata_r,
  // peripheral file
  output logic pf_rd_r,
  output logic pf_wr_r,
  output logic [DATA_W-1:0] pf_addr_r,
  output logic [DATA_W-1:0] pf_wdata_r,
  // stack memory write
  output logic stk_we_r,
  output logic [DATA_W-1:0] stk_addr_r,
  output logic [DATA_W-1:0] stk_wdata_r,
  // architectural state
  output logic [ADDR_W-1:0] program_counter_r,
  output logic [DATA_W-1:0] stack_pointer_r,
  output logic carry_flag_r,
  output logic sign_flag_r,
  output logic zero_flag_r
);
  import lbbc_pkg::*;

  lbbc_state_type state_r, state_nxt;
  lbbc_op_type op_r;
  logic [DATA_W-1:0] src_r;
  logic [DATA_W-1:0] dst_r;
  logic [DATA_W-1:0] daddr_r;
  logic [DATA_W-1:0] ofs_r;
  logic [ADDR_W-1:0] target_r;
  logic [ADDR_W-1:0] npc_r;

  // peripheral forms take their second operand from the peripheral file
  function automatic logic is_periph(input lbbc_op_type op);
    is_periph = (op == LBBC_OP_PERIPH_AND) || (op == LBBC_OP_PERIPH_JUMP_ONE) ||
                (op == LBBC_OP_PERIPH_JUMP_ZERO);
  endfunction : is_periph

  // source operand selection
  wire [DATA_W-1:0] src_sel_val = (src_sel == LBBC_SRC_A) ? reg_a :
                                  (src_sel == LBBC_SRC_B) ? reg_b :
                                  (src_sel == LBBC_SRC_IMM) ? imm : src_reg;

  // peripheral AND refuses a register-file source
  wire bad_src = (op_code == LBBC_OP_PERIPH_AND) && (src_sel == LBBC_SRC_REG); // RL4
  wire accept = op_valid && !busy_r && !bad_src;

  // extended target: direct, register pair, table base plus B
  wire [ADDR_W-1:0] b_wide = {{(ADDR_W-DATA_W){1'b0}}, reg_b};
  wire [ADDR_W-1:0] xtarget = (xmode == LBBC_XM_INDIRECT) ? pair_val : // RL6
                              (xmode == LBBC_XM_INDEXED) ? (xaddr + b_wide) : xaddr; // RL6

  // second operand: peripheral data in exec when a read was made
  // pf_rdata must still stand in exec; it is not captured a cycle earlier
  wire [DATA_W-1:0] opnd = is_periph(op_r) ? pf_rdata : dst_r; // RL8

  // datapath results
  wire [DATA_W-1:0] and_res = src_r & opnd; // RL1
  wire [DATA_W-1:0] andn_res = src_r & ~opnd; // RL9 RL11
  wire [DATA_W:0] cmp_full = {1'b0, dst_r} - {1'b0, src_r}; // RL15 RL16
  wire [DATA_W-1:0] cmp_res = cmp_full[DATA_W-1:0];
  wire cmp_carry = ~cmp_full[DATA_W]; // RL15

  // operation classes seen in exec
  wire is_and = (op_r == LBBC_OP_AND) || (op_r == LBBC_OP_PERIPH_AND);
  wire is_j1 = (op_r == LBBC_OP_REG_JUMP_ONE) || (op_r == LBBC_OP_PERIPH_JUMP_ONE);
  wire is_j0 = (op_r == LBBC_OP_REG_JUMP_ZERO) || (op_r == LBBC_OP_PERIPH_JUMP_ZERO);
  wire is_cmp = (op_r == LBBC_OP_COMPARE) || (op_r == LBBC_OP_EXT_A_COMPARE);
  wire is_clr = (op_r == LBBC_OP_CLEAR);
  wire is_clc = (op_r == LBBC_OP_CLEAR_CARRY);

  // exec phase: the single cycle in which results are committed
  wire in_exec = (state_r == LBBC_ST_EXEC);

  // value whose sign and zero go to the flags
  wire [DATA_W-1:0] flag_val = is_and ? and_res :
                               is_j1 ? and_res : // RL7
                               is_j0 ? andn_res : // RL9
                               is_cmp ? cmp_res :
                               is_clc ? src_r : LBBC_BYTE_RST; // RL14 RL13
  wire flag_load = in_exec &&
                   (is_and || is_j1 || is_j0 || is_cmp || is_clr || is_clc);

  // branch decision and relative target from the following opcode
  // offset is signed; backward jumps wrap through the 16-bit adder
  wire take_jump = (is_j1 && (and_res != '0)) || (is_j0 && (andn_res != '0)); // RL7 RL8 RL9 RL11
  wire [ADDR_W-1:0] ofs_wide = {{(ADDR_W-DATA_W){ofs_r[DATA_W-1]}}, ofs_r};
  wire [ADDR_W-1:0] rel_target = npc_r + ofs_wide; // RL10

  // stack pointer pre-incremented for each push, so it always names
  // the last byte written; it wraps within its own width
  wire [DATA_W-1:0] sp_inc = stack_pointer_r + 8'h01; // RL12

  // push phase decode and the byte it stores, high half first
  wire in_push_hi = (state_r == LBBC_ST_PUSH_HI);
  wire in_push = in_push_hi || (state_r == LBBC_ST_PUSH_LO);
  wire [DATA_W-1:0] push_byte = in_push_hi ? npc_r[ADDR_W-1:DATA_W] : npc_r[DATA_W-1:0]; // RL12

  // sequencer next state
  always_comb begin
    case (state_r)
      LBBC_ST_IDLE: begin
        if (!accept) begin
          state_nxt = LBBC_ST_IDLE;
        end else if (is_periph(op_code)) begin
          state_nxt = LBBC_ST_PREAD;
        end else if (op_code == LBBC_OP_CALL) begin
          state_nxt = LBBC_ST_PUSH_HI;
        end else begin
          state_nxt = LBBC_ST_EXEC;
        end
      end
      LBBC_ST_PREAD: state_nxt = LBBC_ST_EXEC;
      LBBC_ST_PUSH_HI: state_nxt = LBBC_ST_PUSH_LO;
      LBBC_ST_PUSH_LO: state_nxt = LBBC_ST_EXEC;
      LBBC_ST_EXEC: state_nxt = LBBC_ST_IDLE;
      default: state_nxt = LBBC_ST_IDLE;
    endcase
  end

  // state and latched operands
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= LBBC_ST_IDLE;
      op_r <= LBBC_OP_NONE;
      src_r <= LBBC_BYTE_RST;
      dst_r <= LBBC_BYTE_RST;
      daddr_r <= LBBC_BYTE_RST;
      ofs_r <= LBBC_BYTE_RST;
      target_r <= LBBC_PC_RST;
      npc_r <= LBBC_PC_RST;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (accept) begin
        op_r <= op_code;
        // clear-carry tests A; extended compare pits A against the byte
        src_r <= (op_code == LBBC_OP_CLEAR_CARRY) ? reg_a : // RL14
                 (op_code == LBBC_OP_EXT_A_COMPARE) ? xbyte : src_sel_val; // RL16
        dst_r <= (op_code == LBBC_OP_EXT_A_COMPARE) ? reg_a : dst_val; // RL16
        daddr_r <= dst_addr;
        ofs_r <= offset;
        target_r <= xtarget;
        npc_r <= next_pc;
      end
    end
  end

  // handshake: busy while sequencing, done and illegal as pulses
  // busy follows state_nxt, so an offer in the cycle after a take is ignored
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
    end else if (clk_en) begin
      busy_r <= (state_nxt != LBBC_ST_IDLE);
      done_r <= (state_r == LBBC_ST_EXEC);
      illegal_r <= op_valid && !busy_r && bad_src; // RL4
    end
  end

  // register-file write-back for register AND and clear only; tests never write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rf_we_r <= 1'b0;
      rf_waddr_r <= LBBC_BYTE_RST;
      rf_wdata_r <= LBBC_BYTE_RST;
    end else if (clk_en) begin
      rf_we_r <= (state_r == LBBC_ST_EXEC) && ((op_r == LBBC_OP_AND) || is_clr); // RL1 RL13
      rf_waddr_r <= daddr_r;
      rf_wdata_r <= is_clr ? LBBC_BYTE_RST : and_res; // RL13
    end
  end

  // peripheral read first, write back only for the AND form
  // limitation: the write-back carries masked read data, never a shadow copy
  wire pf_rd_req = (state_r == LBBC_ST_IDLE) && accept && is_periph(op_code); // RL3 RL8 RL11
  wire pf_wr_req = (state_r == LBBC_ST_EXEC) && (op_r == LBBC_OP_PERIPH_AND); // RL3
  wire [DATA_W-1:0] pf_addr_sel = pf_wr_req ? daddr_r : dst_addr;

  lbbc_pf_port #(
    .DATA_W(DATA_W)
  ) u_pf_port (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .rd_req(pf_rd_req),
    .wr_req(pf_wr_req),
    .addr(pf_addr_sel),
    .wdata(and_res),
    .pf_rd_r(pf_rd_r),
    .pf_wr_r(pf_wr_r),
    .pf_addr_r(pf_addr_r),
    .pf_wdata_r(pf_wdata_r)
  );

  // call: high byte to sp+1, then low byte to sp+2
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stk_we_r <= 1'b0;
      stk_addr_r <= LBBC_SP_RST;
      stk_wdata_r <= LBBC_BYTE_RST;
      stack_pointer_r <= LBBC_SP_RST;
    end else if (clk_en) begin
      stk_we_r <= in_push; // RL12
      if (in_push) begin
        stack_pointer_r <= sp_inc; // RL12
        stk_addr_r <= sp_inc;
        stk_wdata_r <= push_byte; // RL12
      end
    end
  end

  // program counter: extended target, taken jump, else next opcode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      program_counter_r <= LBBC_PC_RST;
    end else if (clk_en && (state_r == LBBC_ST_EXEC)) begin
      if ((op_r == LBBC_OP_EXT_BRANCH) || (op_r == LBBC_OP_CALL)) begin
        program_counter_r <= target_r; // RL5 RL12
      end else if (take_jump) begin
        program_counter_r <= rel_target; // RL10
      end else begin
        program_counter_r <= npc_r;
      end
    end
  end

  // carry: cleared by logic, tests and clears; compare sets on no borrow.
  // branch and call leave every flag alone
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      carry_flag_r <= LBBC_FLAGS_RST[LBBC_FLAG_C];
    end else if (clk_en && flag_load) begin
      carry_flag_r <= is_cmp ? cmp_carry : 1'b0; // RL2 RL3 RL7 RL9 RL13 RL14 RL15
    end
  end

  // clear forces zero into the flag value, so sign=0 and zero=1
  lbbc_flags #(
    .DATA_W(DATA_W)
  ) u_flags (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(flag_load),
    .value(flag_val), // RL17
    .sign_r(sign_flag_r),
    .zero_r(zero_flag_r)
  );

endmodule : lbbc_exec

/* File: lbbc_exec_checker.sv */
// lbbc_exec_checker: timing and result checks on the lbbc_exec ports.
// assumes one clock domain and clk_en held high while checked.
`timescale 1ns/1ns
module lbbc_exec_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // request side
  input wire logic op_valid,
  input wire lbbc_pkg::lbbc_op_type op_code,
  input wire lbbc_pkg::lbbc_src_type src_sel,
  input wire logic [7:0] imm,
  input wire logic [7:0] dst_val,
  input wire logic [15:0] next_pc,
  // result side
  input wire logic busy_r,
  input wire logic done_r,
  input wire logic illegal_r,
  input wire logic rf_we_r,
  input wire logic [7:0] rf_wdata_r,
  input wire logic pf_rd_r,
  input wire logic pf_wr_r,
  input wire logic stk_we_r,
  input wire logic [7:0] stk_wdata_r,
  input wire logic [15:0] program_counter_r,
  input wire logic carry_flag_r,
  input wire logic sign_flag_r,
  input wire logic zero_flag_r
);
  import lbbc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // accepted request; stalls by clk_en are not modelled here
  wire take = op_valid && !busy_r && clk_en;
  wire [2:0] flags = {zero_flag_r, sign_flag_r, carry_flag_r};

  and_result_a: assert property (take && op_code == LBBC_OP_AND && src_sel == LBBC_SRC_IMM |-> ##2
    rf_we_r && rf_wdata_r == ($past(imm, 2) & $past(dst_val, 2)) && !carry_flag_r
    && sign_flag_r == rf_wdata_r[7] && zero_flag_r == (rf_wdata_r == 8'h00)) else $error("and result wrong");
  periph_seq_a: assert property (take && op_code == LBBC_OP_PERIPH_AND && src_sel != LBBC_SRC_REG |=>
    pf_rd_r ##1 !pf_wr_r ##1 pf_wr_r && done_r && !carry_flag_r) else $error("peripheral and sequence wrong");
  bad_source_a: assert property (take && op_code == LBBC_OP_PERIPH_AND && src_sel == LBBC_SRC_REG |=>
    illegal_r && !pf_rd_r && !rf_we_r && $stable(program_counter_r)) else $error("bad source not refused");
  branch_keep_a: assert property (take && op_code == LBBC_OP_EXT_BRANCH |-> ##2
    done_r && flags == $past(flags, 2)) else $error("branch changed flags");
  call_push_a: assert property (take && op_code == LBBC_OP_CALL |-> ##2
    stk_we_r && {stk_wdata_r, 8'h00} == ($past(next_pc, 2) & 16'hFF00) ##1 stk_we_r
    && {8'h00, stk_wdata_r} == ($past(next_pc, 3) & 16'h00FF) ##1 done_r) else $error("call push order wrong");
  clear_value_a: assert property (take && op_code == LBBC_OP_CLEAR |-> ##2
    rf_we_r && rf_wdata_r == 8'h00 && flags == 3'h4) else $error("clear result wrong");
  compare_carry_a: assert property (take && op_code == LBBC_OP_COMPARE && src_sel == LBBC_SRC_IMM |-> ##2
    !rf_we_r && carry_flag_r == ($past(dst_val, 2) >= $past(imm, 2))
    && zero_flag_r == ($past(dst_val, 2) == $past(imm, 2))) else $error("compare flags wrong");
  done_pulse_a: assert property (done_r |=> !done_r) else $error("done longer than one cycle");
endmodule : lbbc_exec_checker

bind lbbc_exec lbbc_exec_checker u_lbbc_exec_checker (.core_clk(core_clk), .reset_n(reset_n),
  .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code), .src_sel(src_sel), .imm(imm),
  .dst_val(dst_val), .next_pc(next_pc), .busy_r(busy_r), .done_r(done_r), .illegal_r(illegal_r),
  .rf_we_r(rf_we_r), .rf_wdata_r(rf_wdata_r), .pf_rd_r(pf_rd_r), .pf_wr_r(pf_wr_r),
  .stk_we_r(stk_we_r), .stk_wdata_r(stk_wdata_r), .program_counter_r(program_counter_r),
  .carry_flag_r(carry_flag_r), .sign_flag_r(sign_flag_r), .zero_flag_r(zero_flag_r));

/* File: tb_logic_bittest_branch_compare_exec.sv */
// tb_logic_bittest_branch_compare_exec: table-driven bench for lbbc_exec.
// assumes the checker binds itself; clk_en, offset and next_pc stay fixed.
`timescale 1ns/1ns
module tb_logic_bittest_branch_compare_exec;
  import lbbc_pkg::*;
  // one row: op, source, mode, source value, dst, pf data, writes, data, pc, {z,n,c}
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] src;
    logic [1:0] xm;
    logic [7:0] sv;
    logic [7:0] dst;
    logic [7:0] pfr;
    logic [1:0] wr;
    logic [7:0] wd;
    logic [15:0] pc;
    logic [2:0] fl;
  } lbbc_row_type;
  localparam lbbc_row_type ROWS [23] = '{
    '{4'h1, 2'h2, 2'h0, 8'h0F, 8'hFF, 8'h00, 2'h1, 8'h0F, 16'h0200, 3'h0}, // and immediate
    '{4'h1, 2'h0, 2'h0, 8'h3C, 8'hC3, 8'h00, 2'h1, 8'h00, 16'h0200, 3'h4}, // and a, zero
    '{4'h1, 2'h1, 2'h0, 8'h81, 8'h80, 8'h00, 2'h1, 8'h80, 16'h0200, 3'h2}, // and b, sign
    '{4'h3, 2'h0, 2'h0, 8'h00, 8'h12, 8'h34, 2'h0, 8'h00, 16'h1234, 3'h2}, // branch direct
    '{4'h3, 2'h0, 2'h1, 8'h00, 8'hCD, 8'hAB, 2'h0, 8'h00, 16'hABCD, 3'h2}, // branch indirect
    '{4'h3, 2'h1, 2'h2, 8'h81, 8'h12, 8'h34, 2'h0, 8'h00, 16'h12B5, 3'h2}, // branch indexed
    '{4'h4, 2'h1, 2'h0, 8'h81, 8'h80, 8'h00, 2'h0, 8'h00, 16'h01F0, 3'h2}, // one test taken
    '{4'h4, 2'h2, 2'h0, 8'h0F, 8'h10, 8'h00, 2'h0, 8'h00, 16'h0200, 3'h4}, // one test not taken
    '{4'h6, 2'h2, 2'h0, 8'h0F, 8'h0F, 8'h00, 2'h0, 8'h00, 16'h0200, 3'h4}, // zero test not taken
    '{4'h6, 2'h3, 2'h0, 8'hF0, 8'h0F, 8'h00, 2'h0, 8'h00, 16'h01F0, 3'h2}, // zero test taken
    '{4'h5, 2'h0, 2'h0, 8'h3C, 8'h00, 8'h04, 2'h0, 8'h00, 16'h01F0, 3'h0}, // pf one test taken
    '{4'h7, 2'h2, 2'h0, 8'h0F, 8'h00, 8'h0F, 2'h0, 8'h00, 16'h0200, 3'h4}, // pf zero not taken
    '{4'h7, 2'h1, 2'h0, 8'h81, 8'h00, 8'h7E, 2'h0, 8'h00, 16'h01F0, 3'h2}, // pf zero taken
    '{4'h2, 2'h1, 2'h0, 8'h81, 8'h00, 8'hFF, 2'h2, 8'h81, 16'h0200, 3'h2}, // pf and b
    '{4'h2, 2'h2, 2'h0, 8'h0F, 8'h00, 8'hF3, 2'h2, 8'h03, 16'h0200, 3'h0}, // pf and immediate
    '{4'h2, 2'h0, 2'h0, 8'h3C, 8'h00, 8'hF0, 2'h2, 8'h30, 16'h0200, 3'h0}, // pf and a
    '{4'h9, 2'h0, 2'h0, 8'h00, 8'h55, 8'h00, 2'h1, 8'h00, 16'h0200, 3'h4}, // clear
    '{4'hB, 2'h2, 2'h0, 8'h0F, 8'h0F, 8'h00, 2'h0, 8'h00, 16'h0200, 3'h5}, // compare equal
    '{4'hB, 2'h0, 2'h0, 8'h3C, 8'hFF, 8'h00, 2'h0, 8'h00, 16'h0200, 3'h3}, // compare above
    '{4'hA, 2'h0, 2'h0, 8'h80, 8'h00, 8'h00, 2'h0, 8'h00, 16'h0200, 3'h2}, // clear carry
    '{4'hC, 2'h0, 2'h0, 8'h40, 8'h3C, 8'h00, 2'h0, 8'h00, 16'h0200, 3'h1}, // compare a extended
    '{4'h8, 2'h0, 2'h0, 8'h00, 8'h12, 8'h34, 2'h0, 8'h00, 16'h1234, 3'h1}, // call direct
    '{4'h8, 2'h1, 2'h2, 8'h81, 8'h12, 8'h34, 2'h0, 8'h00, 16'h12B5, 3'h1} // call indexed
  };
  // stack writes: two calls from sp 0, high byte first
  localparam logic [15:0] PUSHES [4] = '{16'h0102, 16'h0200, 16'h0302, 16'h0400};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  lbbc_op_type op_code = LBBC_OP_NONE;
  lbbc_src_type src_sel = LBBC_SRC_A;
  lbbc_xmode_type xmode = LBBC_XM_DIRECT;
  logic [7:0] reg_a = 8'h00, reg_b = 8'h00, src_reg = 8'h00, imm = 8'h00, xbyte = 8'h00;
  logic [7:0] dst_val = 8'h00, dst_addr = 8'h00, offset = 8'hF0, pf_rdata = 8'h00;
  logic [15:0] xaddr = 16'h0000, pair_val = 16'h0000, next_pc = 16'h0200;
  logic busy_r, done_r, illegal_r, rf_we_r, pf_rd_r, pf_wr_r, stk_we_r, carry_flag_r, sign_flag_r, zero_flag_r;
  logic [7:0] rf_waddr_r, rf_wdata_r, pf_addr_r, pf_wdata_r, stk_addr_r, stk_wdata_r, stack_pointer_r;
  logic [15:0] program_counter_r;
  logic [15:0] sq [$];
  int n_fail = 0;
  int total_checks = 0;

  lbbc_exec u_lbbc_exec (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .src_sel(src_sel), .xmode(xmode), .reg_a(reg_a), .reg_b(reg_b), .src_reg(src_reg),
    .imm(imm), .dst_val(dst_val), .dst_addr(dst_addr), .offset(offset), .xaddr(xaddr), .pair_val(pair_val),
    .xbyte(xbyte), .next_pc(next_pc), .pf_rdata(pf_rdata), .busy_r(busy_r), .done_r(done_r),
    .illegal_r(illegal_r), .rf_we_r(rf_we_r), .rf_waddr_r(rf_waddr_r), .rf_wdata_r(rf_wdata_r),
    .pf_rd_r(pf_rd_r), .pf_wr_r(pf_wr_r), .pf_addr_r(pf_addr_r), .pf_wdata_r(pf_wdata_r),
    .stk_we_r(stk_we_r), .stk_addr_r(stk_addr_r), .stk_wdata_r(stk_wdata_r),
    .program_counter_r(program_counter_r), .stack_pointer_r(stack_pointer_r),
    .carry_flag_r(carry_flag_r), .sign_flag_r(sign_flag_r), .zero_flag_r(zero_flag_r));

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // unselected sources carry the inverse so a wrong pick shows
  task automatic offer(input lbbc_row_type r);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= lbbc_op_type'(r.op);
    src_sel <= lbbc_src_type'(r.src);
    xmode <= lbbc_xmode_type'(r.xm);
    reg_a <= (r.src == 2'h0) ? r.sv : ~r.sv;
    reg_b <= (r.src == 2'h1) ? r.sv : ~r.sv;
    imm <= (r.src == 2'h2) ? r.sv : ~r.sv;
    src_reg <= (r.src == 2'h3) ? r.sv : ~r.sv;
    dst_val <= r.dst;
    dst_addr <= r.dst ^ 8'hA5;
    pf_rdata <= r.pfr;
    xaddr <= {r.dst, r.pfr};
    pair_val <= {r.pfr, r.dst};
    xbyte <= r.dst;
    @(posedge core_clk);
    op_valid <= 1'b0;
  endtask : offer

  // wait for done under a bound, logging stack writes meanwhile
  task automatic run_op(input lbbc_row_type r);
    int k;
    offer(r);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
      if (stk_we_r === 1'b1) sq.push_back({stk_addr_r, stk_wdata_r});
    end while (done_r !== 1'b1 && k < 8);
    chk(done_r, 1'b1);
    chk(program_counter_r, r.pc);
    chk({zero_flag_r, sign_flag_r, carry_flag_r}, r.fl);
    chk({pf_wr_r, rf_we_r}, r.wr);
    if (r.wr[0]) chk({rf_waddr_r, rf_wdata_r}, {r.dst ^ 8'hA5, r.wd});
    if (r.wr[1]) chk({pf_addr_r, pf_wdata_r}, {8'hA5, r.wd});
  endtask : run_op

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // a hang far beyond the hundred or so cycles needed
  initial begin
    #(100 * 3000);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk(program_counter_r, LBBC_PC_RST);
    chk({busy_r, done_r, stack_pointer_r}, {2'h0, LBBC_SP_RST});
    foreach (ROWS[i]) run_op(ROWS[i]);
    chk(stack_pointer_r, 8'h04);
    for (int i = 0; i < 4; i++) chk(sq[i], PUSHES[i]);
    // register source on peripheral and is refused, state kept
    offer('{4'h2, 2'h3, 2'h0, 8'h11, 8'h00, 8'hFF, 2'h0, 8'h00, 16'h0000, 3'h0});
    @(negedge core_clk);
    chk({illegal_r, pf_rd_r}, 2'h2);
    repeat (3) @(negedge core_clk);
    chk(pf_wr_r, 1'b0);
    chk(program_counter_r, 16'h12B5);
    // reset in mid call aborts the push sequence
    offer(ROWS[21]);
    reset_n <= 1'b0;
    @(negedge core_clk);
    chk({busy_r, stk_we_r, stack_pointer_r}, 10'h000);
    chk(program_counter_r, LBBC_PC_RST);
    @(posedge core_clk);
    reset_n <= 1'b1;
    run_op(ROWS[0]);
    stop_test();
  end
endmodule : tb_logic_bittest_branch_compare_exec
